// >>> hw/rsl_pkg.sv
// Package for the role switch and link supervision sequencer
// Functional notes
// R1 - After role exchange reverse TDD, keep old hopping
// R2 - Send timing offset message before FHS, 0..1249
// R3 - Slave merges offset with coarse FHS clock
// R4 - First FHS: header address zero, payload new address
// R5 - ID acknowledges FHS; then both change parameters
// R6 - Move each slave individually, wait for ack
// R7 - FHS header old address, payload new address
// R8 - On ack adopt own timing, send POLL
// R9 - Start newconnection timer on ack; repeat POLL
// R10 - On timeout fall back to old timing, resend FHS
// R11 - Iterate over all slaves; done when all acked
// R12 - Parked slaves: unpark old, move, repark new
// R13 - Supervision timer restarts on valid addressed packet
// R14 - Supervision timeout resets the connection
// R15 - One supervision timeout for voice and data
// R16 - Supervision limit comes from link manager
// R17 - Parked slaves are not timer supervised
// R18 - Timers count slots; limits loaded before use
package rsl_pkg;
    localparam int          NUM_SLAVES    = 7;
    localparam logic [10:0] ALIGN_MAX_US  = 11'h4E1; // Largest slot offset, 1249 us
    localparam logic [2:0]  BCAST_ADDR    = 3'h0;
    localparam logic [15:0] TIMER_RST_VAL = 16'h0000;

    typedef enum logic [2:0] {
        RSL_PKT_NONE, RSL_PKT_ALIGN, RSL_PKT_FHS, RSL_PKT_POLL, RSL_PKT_UNPARK, RSL_PKT_PARK
    } rsl_pkt_t;

    // Transmit request to the baseband packet engine
    typedef struct packed {
        logic        valid;
        rsl_pkt_t    kind;
        logic [2:0]  hdr_addr;
        logic [2:0]  pay_addr;
        logic [10:0] offset_us;
        logic        new_params;
    } rsl_tx_t;

    // Received packet summary from the packet engine
    typedef struct packed {
        logic       valid;
        logic       hec_ok;
        logic [2:0] addr;
        logic       is_id;
        logic       is_resp;
    } rsl_rx_t;
endpackage

// >>> hw/rsl_slot_timer.sv
// Slot counting timer with loadable limit
`timescale 1ns/1ps
module rsl_slot_timer
    import rsl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        slot_tick,
    input  wire logic        restart,
    input  wire logic        run,
    input  wire logic [15:0] limit,
    output logic             expired
);
    logic [15:0] cnt_q;

    // Counts slots while running, restart has priority
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= TIMER_RST_VAL;
        end else if (restart || !run) begin
            cnt_q <= TIMER_RST_VAL;
        end else if (slot_tick && cnt_q != limit) begin
            cnt_q <= cnt_q + 16'h0001; // [R18]
        end
    end

    assign expired = run && !restart && (cnt_q == limit) && (limit != 16'h0000);
endmodule

// >>> hw/rsl_supervisor.sv
// Link supervision timer for one active link
`timescale 1ns/1ps
module rsl_supervisor
    import rsl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        slot_tick,
    input  wire logic        connected,
    input  wire logic        parked,
    input  wire logic [2:0]  own_addr,
    input  wire rsl_rx_t     rx,
    input  wire logic [15:0] sup_limit,
    output logic             sup_expired
);
    logic hit;

    // Valid header and matching address restart the timer
    assign hit = rx.valid && rx.hec_ok && (rx.addr == own_addr); // [R13]

    // One limit for every link type, parked links excluded
    rsl_slot_timer u_tmr (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .slot_tick (slot_tick),
        .restart   (hit),
        .run       (connected && !parked), // [R15] [R17]
        .limit     (sup_limit),             // [R16]
        .expired   (sup_expired)
    );
endmodule

// >>> hw/rsl_switch_ctrl.sv
// Master-slave role exchange sequencer and link supervision
`timescale 1ns/1ps
module rsl_switch_ctrl
    import rsl_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  slot_tick,
    input  wire logic                  switch_go,
    input  wire logic [10:0]           align_us,
    input  wire logic [NUM_SLAVES-1:0] slave_present,
    input  wire logic [NUM_SLAVES-1:0] slave_parked,
    input  wire logic [3*NUM_SLAVES-1:0] new_addr_map,
    input  wire logic [15:0]           newconn_limit,
    input  wire logic [15:0]           sup_limit,
    input  wire logic                  connected,
    input  wire logic                  tx_ready,
    input  wire rsl_rx_t               rx,
    output rsl_tx_t                    tx_q,
    output logic                       tdd_reversed_q,
    output logic                       own_timing_q,
    output logic                       switch_done_q,
    output logic                       conn_reset_q
);
    import rsl_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PICK, ST_UNPARK, ST_ALIGN, ST_FHS, ST_WAIT_ACK, ST_POLL, ST_WAIT_RESP, ST_REPARK, ST_DONE
    } rsl_state_t;

    rsl_state_t              state_q;
    logic [2:0]              idx_q;
    logic [NUM_SLAVES-1:0]   moved_q;
    logic                    first_q;
    logic                    nc_run_q;
    logic                    nc_restart_q;
    logic                    nc_expired;
    logic                    sup_expired;
    logic [2:0]              old_addr;
    logic [2:0]              new_addr;
    logic                    is_parked;
    logic [2:0]              next_idx;
    logic                    any_left;
    logic [3:0]              pick_r;
    logic                    tx_sent;
    logic                    resp_hit;
    logic                    resp_seen_q;
    logic                    resp_any;

    // Lowest slave still waiting to be moved
    function automatic logic [3:0] pick_next(input logic [NUM_SLAVES-1:0] pend);
        logic [3:0] r;
        r = 4'hF;
        for (int i = NUM_SLAVES - 1; i >= 0; i--) begin
            if (pend[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Old member address is index+1, new address from manager map
    assign old_addr  = idx_q + 3'h1;
    assign new_addr  = new_addr_map[3*idx_q +: 3];
    assign is_parked = slave_parked[idx_q];
    assign pick_r    = pick_next(slave_present & ~moved_q);
    assign any_left  = pick_r != 4'hF;
    assign next_idx  = pick_r[2:0];

    // A send state moves on only once its request has been taken
    assign tx_sent   = tx_q.valid && tx_ready;
    assign resp_hit  = rx.valid && rx.hec_ok && rx.is_resp && (rx.addr == new_addr);
    assign resp_any  = resp_hit || resp_seen_q;

    // Timer for verifying the switch with POLL
    rsl_slot_timer u_nc (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .slot_tick (slot_tick),
        .restart   (nc_restart_q),
        .run       (nc_run_q),
        .limit     (newconn_limit), // [R18]
        .expired   (nc_expired)
    );

    // Link supervision for the addressed slave
    rsl_supervisor u_sup (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .slot_tick   (slot_tick),
        .connected   (connected && !conn_reset_q), // Restart after each loss
        .parked      (is_parked),
        .own_addr    (old_addr),
        .rx          (rx),
        .sup_limit   (sup_limit),
        .sup_expired (sup_expired)
    );

    // Sequencer through every slave of the old piconet
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            idx_q   <= 3'h0;
            moved_q <= '0;
            first_q <= 1'b0;
        end else if (conn_reset_q) begin
            state_q <= ST_IDLE;
            moved_q <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (switch_go) begin
                        moved_q <= '0;
                        first_q <= 1'b1;
                        state_q <= ST_PICK;
                    end
                end
                ST_PICK: begin
                    if (any_left) begin
                        idx_q   <= next_idx; // [R6] [R11]
                        state_q <= slave_parked[next_idx] ? ST_UNPARK : ST_ALIGN; // [R12]
                    end else begin
                        state_q <= ST_DONE; // [R11]
                    end
                end
                ST_UNPARK: if (tx_sent) state_q <= ST_ALIGN; // [R12]
                ST_ALIGN:  if (tx_sent) state_q <= ST_FHS;   // [R2]
                ST_FHS:    if (tx_sent) state_q <= ST_WAIT_ACK; // [R4]
                ST_WAIT_ACK: begin
                    if (rx.valid && rx.hec_ok && rx.is_id) begin
                        state_q <= ST_POLL; // [R5] [R8]
                    end
                end
                ST_POLL: if (tx_sent) state_q <= ST_WAIT_RESP; // [R8]
                ST_WAIT_RESP: begin
                    if (resp_any) begin
                        moved_q[idx_q] <= 1'b1;
                        first_q        <= 1'b0;
                        state_q        <= is_parked ? ST_REPARK : ST_PICK; // [R12]
                    end else if (nc_expired) begin
                        state_q <= ST_FHS; // [R10]
                    end else if (slot_tick) begin
                        state_q <= ST_POLL; // [R9]
                    end
                end
                ST_REPARK: if (tx_sent) state_q <= ST_PICK; // [R12]
                ST_DONE:   state_q <= ST_IDLE;
                default:   state_q <= ST_IDLE;
            endcase
        end
    end

    // Newconnection timer starts on the FHS acknowledgement
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nc_run_q     <= 1'b0;
            nc_restart_q <= 1'b0;
        end else begin
            nc_restart_q <= (state_q == ST_WAIT_ACK) && rx.valid && rx.hec_ok && rx.is_id; // [R9]
            if (state_q == ST_WAIT_ACK && rx.valid && rx.hec_ok && rx.is_id) begin
                nc_run_q <= 1'b1; // [R9]
            end else if (state_q != ST_POLL && state_q != ST_WAIT_RESP) begin
                nc_run_q <= 1'b0;
            end
        end
    end

    // Response that lands while a POLL retry is queued is kept
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            resp_seen_q <= 1'b0;
        end else if (resp_hit && (state_q == ST_POLL || state_q == ST_WAIT_RESP)) begin
            resp_seen_q <= 1'b1; // [R9]
        end else if (state_q != ST_POLL) begin
            resp_seen_q <= 1'b0;
        end
    end

    // Timing selection: reversed TDD held, own timing only after ack
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tdd_reversed_q <= 1'b0;
            own_timing_q   <= 1'b0;
        end else begin
            if (state_q == ST_IDLE && switch_go) begin
                tdd_reversed_q <= 1'b1; // [R1]
            end
            if (state_q == ST_WAIT_ACK && rx.valid && rx.hec_ok && rx.is_id) begin
                own_timing_q <= 1'b1; // [R8]
            end else if (state_q == ST_WAIT_RESP && nc_expired && !resp_any) begin
                own_timing_q <= 1'b0; // [R10]
            end else if (state_q == ST_ALIGN || state_q == ST_UNPARK) begin
                own_timing_q <= 1'b0; // [R6]
            end
            if (conn_reset_q) begin
                tdd_reversed_q <= 1'b0;
                own_timing_q   <= 1'b0;
            end
        end
    end

    // Transmit request drawn from the current state
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_q <= '0;
        end else if (tx_sent) begin
            tx_q <= '0; // Taken, so no second copy reaches the engine
        end else begin
            tx_q <= '0;
            unique case (state_q)
                ST_UNPARK: begin
                    tx_q.valid    <= 1'b1;
                    tx_q.kind     <= RSL_PKT_UNPARK;
                    tx_q.hdr_addr <= old_addr;
                end
                ST_ALIGN: begin
                    tx_q.valid     <= 1'b1;
                    tx_q.kind      <= RSL_PKT_ALIGN;
                    tx_q.hdr_addr  <= old_addr;
                    tx_q.offset_us <= (align_us > ALIGN_MAX_US) ? ALIGN_MAX_US : align_us; // [R2]
                end
                ST_FHS: begin
                    tx_q.valid    <= 1'b1;
                    tx_q.kind     <= RSL_PKT_FHS;
                    tx_q.hdr_addr <= first_q ? BCAST_ADDR : old_addr; // [R4] [R7]
                    tx_q.pay_addr <= new_addr;                        // [R7]
                end
                ST_POLL: begin
                    tx_q.valid      <= 1'b1;
                    tx_q.kind       <= RSL_PKT_POLL;
                    tx_q.hdr_addr   <= new_addr;
                    tx_q.new_params <= 1'b1; // [R5]
                end
                ST_REPARK: begin
                    tx_q.valid      <= 1'b1;
                    tx_q.kind       <= RSL_PKT_PARK;
                    tx_q.hdr_addr   <= new_addr;
                    tx_q.new_params <= 1'b1; // [R12]
                end
                default: begin
                    tx_q <= '0;
                end
            endcase
        end
    end

    // Completion flag and connection reset on supervision loss
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            switch_done_q <= 1'b0;
            conn_reset_q  <= 1'b0;
        end else begin
            switch_done_q <= (state_q == ST_DONE) || (switch_done_q && !switch_go); // [R11]
            conn_reset_q  <= connected && sup_expired; // [R14]
        end
    end

    // Supervision loss leads to reset on the next edge
    sup_reset_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R14]
        connected && sup_expired |=> conn_reset_q) else $error("supervision loss did not reset");

    // Supervision loss gives a single reset pulse, then the timer restarts
    reset_pulse_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R14]
        conn_reset_q |=> !conn_reset_q) else $error("connection reset held");

    // Alignment message precedes FHS, except an FHS resent after a newconnection timeout
    align_first_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
        $rose(state_q == ST_FHS) && !$past(state_q == ST_WAIT_RESP) |-> $past(state_q) == ST_ALIGN)
        else $error("FHS not preceded by alignment");

    // Offset never exceeds its range
    align_range_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R2]
        tx_q.kind == RSL_PKT_ALIGN |-> tx_q.offset_us <= ALIGN_MAX_US) else $error("offset out of range");

    // A request stands unchanged until the packet engine takes it
    tx_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R6]
        tx_q.valid && !tx_ready && state_q != ST_IDLE |=> tx_q == $past(tx_q))
        else $error("request withdrawn before acceptance");

    // Acknowledgement switches to own timing next cycle
    ack_timing_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R8]
        state_q == ST_WAIT_ACK && rx.valid && rx.hec_ok && rx.is_id && !conn_reset_q
        |=> own_timing_q && state_q == ST_POLL ##1 tx_q.kind == RSL_PKT_POLL)
        else $error("ack not followed by POLL");

    // A response during a POLL retry is not lost
    resp_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R9]
        state_q == ST_POLL && resp_hit |=> resp_seen_q) else $error("response during retry lost");

    // Timeout returns to old timing and FHS
    nc_fallback_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R10]
        state_q == ST_WAIT_RESP && nc_expired && !conn_reset_q && !resp_any
        |=> !own_timing_q && state_q == ST_FHS && tdd_reversed_q) else $error("no fallback on timeout");

    // FHS header address zero for first slave
    fhs_addr_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R4] [R7]
        tx_q.kind == RSL_PKT_FHS |-> tx_q.hdr_addr == ($past(first_q) ? BCAST_ADDR : $past(old_addr)))
        else $error("wrong FHS header address");

    // Done only when no slave left to move
    done_all_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R11]
        state_q == ST_DONE |-> (slave_present & ~moved_q) == '0 || $changed(slave_present))
        else $error("switch done with slaves pending");

    // Timer runs while verifying the switch
    nc_running_a: assert property (@(posedge sys_clk) disable iff (sys_rst) // [R9]
        state_q == ST_WAIT_RESP && $past(state_q) == ST_POLL |-> nc_run_q) else $error("newconnection timer idle");
endmodule

// >>> tb/role_switch_link_supervisor_test.sv
// Self-checking bench for the role exchange sequencer and link supervision
`timescale 1ns/1ps
module role_switch_link_supervisor_test;
    import rsl_pkg::*;
    logic                    sys_clk = 0, sys_rst = 1, slot_tick = 0, switch_go = 0, connected = 1;
    logic [10:0]             align_us = '0;
    logic [NUM_SLAVES-1:0]   slave_present = '0, slave_parked = '0;
    logic [3*NUM_SLAVES-1:0] new_addr_map = '0;
    logic [15:0]             newconn_limit = 16'h0064, sup_limit = '0, lfsr = 16'h002F, rnd;
    logic                    tx_ready, slow = 0, mute_en = 0, tdd_q, own_q, done_q, creset_q;
    logic [2:0]              mute_addr = '0;
    rsl_tx_t                 tx_q, last_q;
    rsl_rx_t                 rx;
    rsl_tx_t                 got[$], exp_q[$];
    int                      n_fail = 0, check_count = 0, tick_n = 0;

    always #5 sys_clk = ~sys_clk;

    // One slot every four clocks
    always @(posedge sys_clk) begin
        tick_n <= (tick_n + 1) % 4;
        slot_tick <= (tick_n == 3);
    end

    // Log each new packet request, repeats of the same one folded
    always @(posedge sys_clk) begin
        if (sys_rst) last_q <= '0;
        else if (tx_q.valid === 1'b1 && tx_q !== last_q) begin
            got.push_back(tx_q);
            last_q <= tx_q;
        end
    end

    rsl_switch_ctrl i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .slot_tick(slot_tick), .switch_go(switch_go),
        .align_us(align_us), .slave_present(slave_present), .slave_parked(slave_parked),
        .new_addr_map(new_addr_map), .newconn_limit(newconn_limit), .sup_limit(sup_limit),
        .connected(connected), .tx_ready(tx_ready), .rx(rx), .tx_q(tx_q), .tdd_reversed_q(tdd_q),
        .own_timing_q(own_q), .switch_done_q(done_q), .conn_reset_q(creset_q));
    rsl_peer_model i_peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .tx(tx_q), .slow(slow), .mute_en(mute_en),
        .mute_addr(mute_addr), .tx_ready(tx_ready), .rx(rx));

    function automatic logic [15:0] next_rand(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Expected request order for the loaded slave set
    function automatic void build_exp(logic mute);
        rsl_tx_t e;
        logic    first;
        first = 1'b1;
        exp_q.delete();
        for (int i = 0; i < NUM_SLAVES; i++) begin
            if (slave_present[i]) begin
                e = '0;
                e.valid = 1'b1;
                if (slave_parked[i]) begin
                    e.kind = RSL_PKT_UNPARK;
                    exp_q.push_back(e);
                end
                e.kind = RSL_PKT_ALIGN;
                e.offset_us = (align_us > ALIGN_MAX_US) ? ALIGN_MAX_US : align_us;
                exp_q.push_back(e);
                e = '{valid: 1'b1, kind: RSL_PKT_FHS, hdr_addr: first ? BCAST_ADDR : 3'(i + 1),
                      pay_addr: new_addr_map[3*i +: 3], offset_us: 11'h000, new_params: 1'b0};
                exp_q.push_back(e);
                exp_q.push_back('{1'b1, RSL_PKT_POLL, e.pay_addr, 3'h0, 11'h000, 1'b1});
                if (mute && e.pay_addr == mute_addr) begin
                    exp_q.push_back(e);
                    exp_q.push_back('{1'b1, RSL_PKT_POLL, e.pay_addr, 3'h0, 11'h000, 1'b1});
                end
                if (slave_parked[i]) exp_q.push_back('{1'b1, RSL_PKT_PARK, 3'h0, 3'h0, 11'h000, 1'b0});
                first = 1'b0;
            end
        end
    endfunction

    // Fields that the sequence fixes for each kind of request
    function automatic logic same(rsl_tx_t a, rsl_tx_t b);
        if (a.kind !== b.kind) return 1'b0;
        if (a.kind == RSL_PKT_ALIGN) return a.offset_us === b.offset_us;
        if (a.kind == RSL_PKT_FHS) return {a.hdr_addr, a.pay_addr, a.new_params} ===
                                          {b.hdr_addr, b.pay_addr, b.new_params};
        if (a.kind == RSL_PKT_POLL) return {a.hdr_addr, a.new_params} === {b.hdr_addr, b.new_params};
        return 1'b1;
    endfunction

    task automatic check(input logic [31:0] got_v, input logic [31:0] exp_v);
        check_count++;
        if (got_v !== exp_v) begin
            n_fail++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        got.delete();
    endtask

    // One full role exchange over the given slave set
    task automatic run_case(input logic [6:0] pres, input logic [6:0] park, input logic [10:0] al,
                            input int r, input logic sl, input logic mute);
        int k;
        do_reset();
        slave_present <= pres;
        slave_parked <= park;
        align_us <= al;
        slow <= sl;
        mute_en <= mute;
        mute_addr <= 3'(r % 7 + 1);
        sup_limit <= 16'h0000;
        connected <= 1'b1;
        newconn_limit <= mute ? 16'h0004 : 16'h0064;
        for (k = 0; k < NUM_SLAVES; k++) new_addr_map[3*k +: 3] <= 3'((k + r) % 7 + 1);
        @(posedge sys_clk);
        switch_go <= 1'b1;
        @(posedge sys_clk);
        switch_go <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check(32'(tdd_q), 32'h1);
        for (k = 0; k < 4000 && done_q !== 1'b1; k++) @(posedge sys_clk);
        check(32'(done_q), 32'h1);
        check(32'(own_q), 32'h1);
        build_exp(mute);
        check(32'(got.size()), 32'(exp_q.size()));
        for (k = 0; k < exp_q.size() && k < got.size(); k++) begin
            check(32'(same(got[k], exp_q[k])), 32'h1);
            if (!same(got[k], exp_q[k])) $display("MISMATCH at %0t: got %h expected %h", $time, got[k], exp_q[k]);
        end
    endtask

    // Idle link with no traffic: reset comes only when supervised
    task automatic sup_case(input logic [15:0] lim, input logic [6:0] park, input logic conn, input logic fire);
        int k;
        do_reset();
        sup_limit <= lim;
        slave_parked <= park;
        connected <= conn;
        for (k = 0; k < 200 && creset_q !== 1'b1; k++) @(posedge sys_clk);
        if (fire) check(32'(k >= (lim - 2) * 4 && k <= (lim + 2) * 4), 32'h1);
        else check(k, 200);
    endtask

    initial begin
        do_reset();
        sup_case(16'h0006, 7'h00, 1'b1, 1'b1);
        sup_case(16'h0006, 7'h7F, 1'b1, 1'b0);
        sup_case(16'h0006, 7'h00, 1'b0, 1'b0);
        sup_case(16'h0000, 7'h00, 1'b1, 1'b0);
        run_case(7'h7F, 7'h7F, 11'h7FF, 0, 1'b0, 1'b0);
        run_case(7'h01, 7'h00, 11'h000, 3, 1'b1, 1'b1);
        run_case(7'h45, 7'h04, 11'h4E1, 5, 1'b0, 1'b1);
        for (int n = 0; n < 6; n++) begin
            lfsr = next_rand(lfsr);
            rnd = next_rand(lfsr);
            lfsr = next_rand(rnd);
            run_case(lfsr[6:0] | 7'h01, lfsr[13:7], rnd[10:0], int'(rnd[14:12]) % 7, rnd[15], 1'b0);
        end
        test_done();
    end

    // Cut a hang short
    initial begin
        #500000;
        n_fail++;
        test_done();
    end
endmodule

// >>> tb/rsl_peer_model.sv
// Behavioural peer link controller that answers the switch sequencer
`timescale 1ns/1ps
module rsl_peer_model (
    input  wire logic             sys_clk,
    input  wire logic             sys_rst,
    input  wire rsl_pkg::rsl_tx_t tx,
    input  wire logic             slow,
    input  wire logic             mute_en,
    input  wire logic [2:0]       mute_addr,
    output logic                  tx_ready,
    output rsl_pkg::rsl_rx_t      rx
);
    import rsl_pkg::*;
    logic [3:0] wait_q;
    logic       ack_due_q, resp_due_q, armed_q, muted_q, align_ok_q;
    logic [2:0] old_q, new_q;
    wire        sent = tx.valid && tx_ready;

    // Packet engine stalls every other cycle when slow
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) tx_ready <= 1'b0;
        else tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // ID after each FHS, one response to the first POLL after the ID
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            {wait_q, ack_due_q, resp_due_q, armed_q, muted_q, align_ok_q, old_q, new_q} <= '0;
            rx <= '0;
        end else begin
            rx <= {1'b0, ~rx[5:0]}; // Idle: valid cleared, other fields inverted every cycle
            if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
            if (sent && tx.kind == RSL_PKT_FHS) begin
                ack_due_q <= align_ok_q; // No window without the fine offset
                old_q <= tx.hdr_addr;
                new_q <= tx.pay_addr;
                wait_q <= slow ? 4'h9 : 4'h3;
            end else if (sent && tx.kind == RSL_PKT_POLL && armed_q) begin
                armed_q <= 1'b0;
                if (mute_en && !muted_q && tx.hdr_addr == mute_addr) begin
                    muted_q <= 1'b1;
                end else begin
                    resp_due_q <= 1'b1;
                    wait_q <= slow ? 4'h9 : 4'h3;
                end
            end
            if (sent && tx.kind == RSL_PKT_ALIGN) begin
                align_ok_q <= (tx.offset_us <= ALIGN_MAX_US); // Offset accepted only up to ALIGN_MAX_US
            end
            if (wait_q == 4'h0 && ack_due_q) begin
                ack_due_q <= 1'b0;
                armed_q <= 1'b1;
                rx <= '{valid: 1'b1, hec_ok: 1'b1, addr: old_q, is_id: 1'b1, is_resp: 1'b0};
            end else if (wait_q == 4'h0 && resp_due_q) begin
                resp_due_q <= 1'b0;
                align_ok_q <= 1'b0; // Next slave needs its own offset
                rx <= '{valid: 1'b1, hec_ok: 1'b1, addr: new_q, is_id: 1'b0, is_resp: 1'b1};
            end
        end
    end
endmodule
